// ===== core/gpio_port_defines.vh
// Constants for the six-port I/O block: register addresses, reset values, field positions.
// Assumes an 8-bit internal bus with a 16-bit address and single-cycle strobes.
// Summary of operation
// - First port has four latched pins, each with its own direction bit.
// - First port pull-ups enabled together by one bit, only for input pins.
// - Second port has two latched pins; pair pull-up by one bit, inputs only.
// - Third port has three pins; each pull-up bit works in either direction.
// - Fourth port has four pins, group pull-up on inputs, also key-return inputs.
// - Fifth port has two pins; one shares timer output, other external interrupt.
// - Sixth port has six pins, each switchable to a display segment output.
// - Direction bit zero drives the pin; one turns the buffer off for input.
// - Reset loads all ones into five direction registers, 3FH into the sixth.
// - Direction registers take whole-byte writes only, each register independently.
// - A level change on the interrupt-shared pin in output mode raises a request.
// - Reads return latch for output pins and pin level for input pins.
// - Writes update the latch even in input mode; latch holds until next write.
// - Function bit one routes sixth-port pin to the segment driver, zero keeps GPIO.
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_PORT0_DATA     16'hff00
`define ADDR_PORT1_DATA     16'hff01
`define ADDR_PORT2_DATA     16'hff02
`define ADDR_PORT4_DATA     16'hff04
`define ADDR_PORT6_DATA     16'hff06
`define ADDR_PORT8_DATA     16'hff08
`define ADDR_PORT0_DIR      16'hff20
`define ADDR_PORT1_DIR      16'hff21
`define ADDR_PORT2_DIR      16'hff22
`define ADDR_PORT4_DIR      16'hff24
`define ADDR_PORT6_DIR      16'hff26
`define ADDR_PORT8_DIR      16'hff28
`define ADDR_BITWISE_PU     16'hff32
`define ADDR_SEG_FUNC       16'hff58
`define ADDR_GROUP_PU       16'hfff7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DIR             8'hff
`define RST_DIR8            8'h3f
`define RST_ZERO            8'h00

// ----------------------------------------
// Field positions of the group pull-up register
// ----------------------------------------
`define GPU_PORT0_BIT       0
`define GPU_PORT1_BIT       1
`define GPU_PORT4_BIT       4

`endif

// ===== core/gpio_port_bank.v
// One latched I/O port: output latch, direction register, read mux.
// Assumes the parent decodes addresses into per-register write strobes.
`timescale 1ns/1ps
module gpio_port_bank #(
  parameter       WIDTH     = 4,
  parameter [7:0] DIR_RESET = 8'hff
) (
  input  wire             i_mclk,
  input  wire             i_arst_n,
  input  wire             i_wr_latch,
  input  wire             i_wr_dir,
  input  wire [7:0]       i_wdata,
  input  wire [WIDTH-1:0] i_pin,
  output wire [7:0]       o_rdata,
  output wire [7:0]       o_dir,
  output wire [WIDTH-1:0] o_latch
);

  reg  [WIDTH-1:0] latch_q;
  reg  [7:0]       dir_q;
  wire [WIDTH-1:0] rd_bits;

  // ----------------------------------------
  // Latch and direction
  // ----------------------------------------
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      latch_q <= {WIDTH{1'b0}};
      dir_q   <= DIR_RESET;
    end
    else
    begin
      if (i_wr_latch)
        latch_q <= i_wdata[WIDTH-1:0];
      if (i_wr_dir)
        dir_q <= i_wdata;
    end
  end

  // Input pins read the pad, output pins the latch
  assign rd_bits = (dir_q[WIDTH-1:0] & i_pin) | (~dir_q[WIDTH-1:0] & latch_q);
  assign o_rdata = {{(8-WIDTH){1'b0}}, rd_bits};
  assign o_dir   = dir_q;
  assign o_latch = latch_q;

endmodule // gpio_port_bank

// ===== core/gpio_port_ctrl.v
// Six general-purpose ports with direction, pull-up and segment select.
// Assumes a CPU bus with one-cycle write and read strobes, synchronous pins.
`timescale 1ns/1ps
`include "gpio_port_defines.vh"
module gpio_port_ctrl (
  input  wire        i_mclk,
  input  wire        i_arst_n,
  input  wire [15:0] i_addr,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  output wire        o_rd_hit,
  input  wire [3:0]  i_p0_pin,
  output wire [3:0]  o_p0_out,
  output wire [3:0]  o_p0_oe_n,
  output wire [3:0]  o_p0_pullup,
  input  wire [1:0]  i_p1_pin,
  output wire [1:0]  o_p1_out,
  output wire [1:0]  o_p1_oe_n,
  output wire [1:0]  o_p1_pullup,
  input  wire [2:0]  i_p2_pin,
  output wire [2:0]  o_p2_out,
  output wire [2:0]  o_p2_oe_n,
  output wire [2:0]  o_p2_pullup,
  output wire        o_serial_data_in,
  input  wire        i_serial_clock_line,
  input  wire        i_serial_data_out,
  output wire        o_serial_clock_line,
  input  wire [3:0]  i_p4_pin,
  output wire [3:0]  o_p4_out,
  output wire [3:0]  o_p4_oe_n,
  output wire [3:0]  o_p4_pullup,
  output wire [3:0]  o_key_return_inputs,
  input  wire [1:0]  i_p6_pin,
  output wire [1:0]  o_p6_out,
  output wire [1:0]  o_p6_oe_n,
  input  wire        i_timer_output_line,
  output wire        o_ext_irq_pin,
  output wire        o_ext_irq_req,
  input  wire [5:0]  i_p8_pin,
  output wire [5:0]  o_p8_out,
  output wire [5:0]  o_p8_oe_n,
  input  wire [5:0]  i_segment_outputs,
  output wire [5:0]  o_segment_enable
);

  wire [7:0] rd0, rd1, rd2, rd4, rd6, rd8;
  wire [7:0] dir0, dir1, dir2, dir4, dir6, dir8;
  wire [3:0] lat0;
  wire [1:0] lat1;
  wire [2:0] lat2;
  wire [3:0] lat4;
  wire [1:0] lat6;
  wire [5:0] lat8;
  reg  [7:0] group_pullup_select_q;
  reg  [7:0] bitwise_pullup_select_q;
  reg  [7:0] segment_function_select_q;
  reg        irq_level_q;
  reg        irq_out_mode_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function hit;
    input [15:0] a;
    input [15:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  gpio_port_bank #(.WIDTH(4), .DIR_RESET(`RST_DIR)) u_p0 (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_wr_latch (i_wr & hit(i_addr, `ADDR_PORT0_DATA)),
    .i_wr_dir   (i_wr & hit(i_addr, `ADDR_PORT0_DIR)),
    .i_wdata    (i_wdata),
    .i_pin      (i_p0_pin),
    .o_rdata    (rd0),
    .o_dir      (dir0),
    .o_latch    (lat0)
  );

  gpio_port_bank #(.WIDTH(2), .DIR_RESET(`RST_DIR)) u_p1 (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_wr_latch (i_wr & hit(i_addr, `ADDR_PORT1_DATA)),
    .i_wr_dir   (i_wr & hit(i_addr, `ADDR_PORT1_DIR)),
    .i_wdata    (i_wdata),
    .i_pin      (i_p1_pin),
    .o_rdata    (rd1),
    .o_dir      (dir1),
    .o_latch    (lat1)
  );

  gpio_port_bank #(.WIDTH(3), .DIR_RESET(`RST_DIR)) u_p2 (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_wr_latch (i_wr & hit(i_addr, `ADDR_PORT2_DATA)),
    .i_wr_dir   (i_wr & hit(i_addr, `ADDR_PORT2_DIR)),
    .i_wdata    (i_wdata),
    .i_pin      (i_p2_pin),
    .o_rdata    (rd2),
    .o_dir      (dir2),
    .o_latch    (lat2)
  );

  gpio_port_bank #(.WIDTH(4), .DIR_RESET(`RST_DIR)) u_p4 (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_wr_latch (i_wr & hit(i_addr, `ADDR_PORT4_DATA)),
    .i_wr_dir   (i_wr & hit(i_addr, `ADDR_PORT4_DIR)),
    .i_wdata    (i_wdata),
    .i_pin      (i_p4_pin),
    .o_rdata    (rd4),
    .o_dir      (dir4),
    .o_latch    (lat4)
  );

  gpio_port_bank #(.WIDTH(2), .DIR_RESET(`RST_DIR)) u_p6 (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_wr_latch (i_wr & hit(i_addr, `ADDR_PORT6_DATA)),
    .i_wr_dir   (i_wr & hit(i_addr, `ADDR_PORT6_DIR)),
    .i_wdata    (i_wdata),
    .i_pin      (i_p6_pin),
    .o_rdata    (rd6),
    .o_dir      (dir6),
    .o_latch    (lat6)
  );

  gpio_port_bank #(.WIDTH(6), .DIR_RESET(`RST_DIR8)) u_p8 (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_wr_latch (i_wr & hit(i_addr, `ADDR_PORT8_DATA)),
    .i_wr_dir   (i_wr & hit(i_addr, `ADDR_PORT8_DIR)),
    .i_wdata    (i_wdata),
    .i_pin      (i_p8_pin),
    .o_rdata    (rd8),
    .o_dir      (dir8),
    .o_latch    (lat8)
  );

  // ----------------------------------------
  // Pull-up and segment function registers
  // ----------------------------------------
  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      group_pullup_select_q     <= `RST_ZERO;
      bitwise_pullup_select_q   <= `RST_ZERO;
      segment_function_select_q <= `RST_ZERO;
    end
    else if (i_wr)
    begin
      if (hit(i_addr, `ADDR_GROUP_PU))
        group_pullup_select_q <= i_wdata & 8'h13;
      if (hit(i_addr, `ADDR_BITWISE_PU))
        bitwise_pullup_select_q <= i_wdata & 8'h07;
      if (hit(i_addr, `ADDR_SEG_FUNC))
        segment_function_select_q <= i_wdata & 8'h3f;
    end
  end

  // ----------------------------------------
  // Pin drivers; direction one releases the pad
  // ----------------------------------------
  // Serial clock and data are ANDed with the latch, so latch must be one to pass them
  assign o_p0_out  = lat0;
  assign o_p0_oe_n = dir0[3:0];
  assign o_p1_out  = lat1;
  assign o_p1_oe_n = dir1[1:0];
  assign o_p2_out  = {lat2[2], lat2[1] & i_serial_data_out, lat2[0] & i_serial_clock_line};
  assign o_p2_oe_n = dir2[2:0];
  assign o_p4_out  = lat4;
  assign o_p4_oe_n = dir4[3:0];
  // Timer output is ORed with latch, so latch must be zero to pass it
  assign o_p6_out  = {lat6[1], lat6[0] | i_timer_output_line};
  assign o_p6_oe_n = dir6[1:0];
  assign o_p8_out  = lat8;
  assign o_p8_oe_n = dir8[5:0] | segment_function_select_q[5:0];

  // Segment driver owns pads whose select bit is set
  assign o_segment_enable = segment_function_select_q[5:0];

  assign o_p0_pullup = {4{group_pullup_select_q[`GPU_PORT0_BIT]}} & dir0[3:0];
  assign o_p1_pullup = {2{group_pullup_select_q[`GPU_PORT1_BIT]}} & dir1[1:0];
  assign o_p4_pullup = {4{group_pullup_select_q[`GPU_PORT4_BIT]}} & dir4[3:0];
  assign o_p2_pullup = bitwise_pullup_select_q[2:0];

  // ----------------------------------------
  // Alternate-function inputs
  // ----------------------------------------
  assign o_key_return_inputs = i_p4_pin;
  assign o_serial_data_in    = i_p2_pin[2];
  assign o_serial_clock_line = i_p2_pin[0];

  // ----------------------------------------
  // External interrupt pin
  // ----------------------------------------
  // Output mode feeds the driven level back, so its changes raise requests
  assign o_ext_irq_pin = dir6[1] ? i_p6_pin[1] : lat6[1];

  always @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      irq_level_q    <= 1'b0;
      irq_out_mode_q <= 1'b0;
    end
    else
    begin
      irq_level_q    <= lat6[1];
      irq_out_mode_q <= ~dir6[1];
    end
  end

  assign o_ext_irq_req = irq_out_mode_q & ~dir6[1] & (irq_level_q != lat6[1]);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  assign o_rd_hit = i_rd;

  always @*
  begin
    case (i_addr)
      `ADDR_PORT0_DATA: o_rdata = rd0;
      `ADDR_PORT1_DATA: o_rdata = rd1;
      `ADDR_PORT2_DATA: o_rdata = rd2;
      `ADDR_PORT4_DATA: o_rdata = rd4;
      `ADDR_PORT6_DATA: o_rdata = rd6;
      `ADDR_PORT8_DATA: o_rdata = rd8;
      `ADDR_PORT0_DIR:  o_rdata = dir0;
      `ADDR_PORT1_DIR:  o_rdata = dir1;
      `ADDR_PORT2_DIR:  o_rdata = dir2;
      `ADDR_PORT4_DIR:  o_rdata = dir4;
      `ADDR_PORT6_DIR:  o_rdata = dir6;
      `ADDR_PORT8_DIR:  o_rdata = dir8;
      `ADDR_GROUP_PU:   o_rdata = group_pullup_select_q;
      `ADDR_BITWISE_PU: o_rdata = bitwise_pullup_select_q;
      `ADDR_SEG_FUNC:   o_rdata = segment_function_select_q;
      default:          o_rdata = 8'h00;
    endcase
  end

endmodule // gpio_port_ctrl

// ===== verif/gpio_port_ctrl_monitor.sv
// Checker for the six-port I/O block, bound to its top module.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module gpio_port_ctrl_monitor (
  input logic        i_mclk,
  input logic        i_arst_n,
  input logic [15:0] i_addr,
  input logic        i_wr,
  input logic [7:0]  i_wdata,
  input logic [3:0]  o_p0_oe_n,
  input logic [3:0]  o_p0_pullup,
  input logic [3:0]  o_p4_oe_n,
  input logic [3:0]  o_p4_pullup,
  input logic [2:0]  o_p2_pullup,
  input logic [1:0]  o_p6_out,
  input logic [1:0]  o_p6_oe_n,
  input logic        o_ext_irq_req,
  input logic [5:0]  o_p8_oe_n,
  input logic [5:0]  o_segment_enable
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  a_reset_all_input: assert property ($rose(i_arst_n) |-> o_p0_oe_n == 4'hf && o_p8_oe_n == 6'h3f)
    else $error("pins not all inputs after reset");
  a_dir_drives_pin: assert property (i_wr && i_addr == 16'hff20 |=> o_p0_oe_n == $past(i_wdata[3:0]))
    else $error("direction write not seen on enables");
  a_segment_select: assert property (i_wr && i_addr == 16'hff58 |=> o_segment_enable == $past(i_wdata[5:0]))
    else $error("segment select not stored");
  a_segment_owns_pad: assert property (&(o_p8_oe_n | ~o_segment_enable))
    else $error("port drives a segment pad");
  a_pullup_inputs_only: assert property ((o_p0_pullup & ~o_p0_oe_n) == 4'h0 && (o_p4_pullup & ~o_p4_oe_n) == 4'h0)
    else $error("pull-up on an output pin");
  a_group_pullup: assert property (o_p0_pullup == 4'h0 || o_p0_pullup == o_p0_oe_n)
    else $error("group pull-up not uniform");
  a_bitwise_pullup: assert property (i_wr && i_addr == 16'hff32 |=> o_p2_pullup == $past(i_wdata[2:0]))
    else $error("bitwise pull-up not stored");
  a_latch_write: assert property (i_wr && i_addr == 16'hff06 |=> o_p6_out[1] == $past(i_wdata[1]))
    else $error("latch write lost");
  a_irq_cause: assert property (o_ext_irq_req |-> $changed(o_p6_out[1]) && !o_p6_oe_n[1])
    else $error("request without level change");
  a_irq_raised: assert property ($changed(o_p6_out[1]) && !o_p6_oe_n[1] && !$past(o_p6_oe_n[1]) |-> o_ext_irq_req)
    else $error("level change without request");
endmodule // gpio_port_ctrl_monitor

bind gpio_port_ctrl gpio_port_ctrl_monitor i_mon (.*);

// ===== verif/gpio_pad_model.sv
// Pad model: each pin is driven by the port or by the outside world.
// Assumes a pull-up wins over the outside source on a released pad.
`timescale 1ns/1ps
module gpio_pad_model #(
  parameter W = 4
) (
  input  logic [W-1:0] i_o,
  input  logic [W-1:0] i_e,
  input  logic [W-1:0] i_u,
  input  logic [W-1:0] i_x,
  output logic [W-1:0] o_p
);
  // Released pad shows the pull-up or the outside value, never the last drive
  assign o_p = (~i_e & i_o) | (i_e & (i_u | i_x));
endmodule // gpio_pad_model

// ===== verif/multi_port_io_direction_control_test.sv
// Self-checking bench for the six-port I/O block.
// Assumes the pad model and checker are compiled before it.
`timescale 1ns/1ps
module multi_port_io_direction_control_test;
  logic        i_mclk, i_arst_n, i_wr, i_rd, o_rd_hit, o_serial_data_in, o_serial_clock_line;
  logic        i_serial_clock_line, i_serial_data_out, i_timer_output_line, o_ext_irq_pin, o_ext_irq_req;
  logic [15:0] i_addr, nq;
  logic [7:0]  i_wdata, o_rdata;
  logic [3:0]  i_p0_pin, o_p0_out, o_p0_oe_n, o_p0_pullup, i_p4_pin, o_p4_out, o_p4_oe_n, o_p4_pullup;
  logic [3:0]  o_key_return_inputs;
  logic [1:0]  i_p1_pin, o_p1_out, o_p1_oe_n, o_p1_pullup, i_p6_pin, o_p6_out, o_p6_oe_n;
  logic [2:0]  i_p2_pin, o_p2_out, o_p2_oe_n, o_p2_pullup;
  logic [5:0]  i_p8_pin, o_p8_out, o_p8_oe_n, i_segment_outputs, o_segment_enable;
  logic [20:0] ext;
  logic [15:0] q[$];
  int          errors, check_count, irqs;
  logic [31:0] seed = 26;
  logic [7:0]  pa[6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08};
  logic [7:0]  pm[6] = '{8'h0f, 8'h03, 8'h07, 8'h0f, 8'h03, 8'h3f};
  int          po[6] = '{0, 4, 6, 9, 13, 15};
  logic [7:0]  dv[6], lv[6];

  gpio_port_ctrl i_dut (.*);
  gpio_pad_model #(4) i_pad0 (.i_o(o_p0_out), .i_e(o_p0_oe_n), .i_u(o_p0_pullup), .i_x(ext[3:0]), .o_p(i_p0_pin));
  gpio_pad_model #(2) i_pad1 (.i_o(o_p1_out), .i_e(o_p1_oe_n), .i_u(o_p1_pullup), .i_x(ext[5:4]), .o_p(i_p1_pin));
  gpio_pad_model #(3) i_pad2 (.i_o(o_p2_out), .i_e(o_p2_oe_n), .i_u(o_p2_pullup), .i_x(ext[8:6]), .o_p(i_p2_pin));
  gpio_pad_model #(4) i_pad4 (.i_o(o_p4_out), .i_e(o_p4_oe_n), .i_u(o_p4_pullup), .i_x(ext[12:9]), .o_p(i_p4_pin));
  gpio_pad_model #(2) i_pad6 (.i_o(o_p6_out), .i_e(o_p6_oe_n), .i_u(2'b00), .i_x(ext[14:13]), .o_p(i_p6_pin));
  gpio_pad_model #(6) i_pad8 (.i_o(o_p8_out), .i_e(o_p8_oe_n), .i_u(6'h00), .i_x(ext[20:15]), .o_p(i_p8_pin));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %0s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_mclk);
    #1;
    i_wr = 1'b0;
  endtask

  // Expected value noted now, compared when the read strobe is seen
  task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_mclk);
    #1;
    i_addr = a;
    i_rd = 1'b1;
    q.push_back({m, e});
    @(posedge i_mclk);
    #1;
    i_rd = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk)
    if (o_rd_hit === 1'b1 && q.size() > 0)
    begin
      nq = q.pop_front();
      chk("rdata", o_rdata & nq[15:8], nq[7:0] & nq[15:8]);
    end

  always @(posedge i_mclk)
    if (o_ext_irq_req === 1'b1)
      irqs++;

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {i_arst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_serial_clock_line, i_serial_data_out} = 2'b11;
    i_timer_output_line = 1'b0;
    i_segment_outputs = 6'h00;
    ext = 21'(xs());
    repeat (6) @(posedge i_mclk);
    #1 i_arst_n = 1'b1;
    for (int k = 0; k < 6; k++)
      rd({8'hff, pa[k] + 8'h20}, 8'hff, k < 5 ? 8'hff : 8'h3f);
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      dv[k] = k < 5 ? 8'(xs()) | ~pm[k] : 8'(xs()) & pm[k];
      lv[k] = 8'(xs());
      wr({8'hff, pa[k] + 8'h20}, dv[k]);
      wr({8'hff, pa[k]}, lv[k]);
    end
    ext = 21'(xs());
    for (int k = 0; k < 6; k++)
    begin
      rd({8'hff, pa[k] + 8'h20}, 8'hff, dv[k]);
      rd({8'hff, pa[k]}, pm[k], ~dv[k] & lv[k] | dv[k] & 8'(ext >> po[k]));
    end
    // Latch written while input must survive the switch to output
    for (int k = 0; k < 6; k++)
    begin
      wr({8'hff, pa[k] + 8'h20}, k < 5 ? ~pm[k] : 8'h00);
      rd({8'hff, pa[k]}, pm[k], lv[k]);
    end
    $display("test direction and latch done");
    wr(16'hfff7, 8'h13);
    wr(16'hff32, 8'h07);
    for (int k = 0; k < 4; k++)
    begin
      wr({8'hff, pa[k] + 8'h20}, 8'hfd);
      rd({8'hff, pa[k]}, pm[k], 8'hfd | lv[k]);
    end
    chk("p2 pullup", {5'h00, o_p2_pullup}, 8'h07);
    chk("p0 pullup", {4'h0, o_p0_pullup}, 8'h0d);
    chk("p1 pullup", {6'h00, o_p1_pullup}, 8'h01);
    chk("p4 pullup", {4'h0, o_p4_pullup}, 8'h0d);
    $display("test pull-up done");
    wr(16'hff26, 8'hfd);
    wr(16'hff06, 8'h00);
    repeat (2) @(posedge i_mclk);
    irqs = 0;
    wr(16'hff06, 8'h02);
    wr(16'hff06, 8'h02);
    wr(16'hff06, 8'h00);
    wr(16'hff26, 8'hff);
    wr(16'hff06, 8'h02);
    repeat (2) @(posedge i_mclk);
    chk("irq count", 8'(irqs), 8'h02);
    $display("test interrupt pin done");
    wr(16'hff28, 8'h00);
    wr(16'hff58, 8'h3f);
    chk("seg enable", {2'b00, o_segment_enable}, 8'h3f);
    chk("p8 oe_n", {2'b00, o_p8_oe_n}, 8'h3f);
    wr(16'hff58, 8'h05);
    chk("p8 oe_n", {2'b00, o_p8_oe_n}, 8'h05);
    chk("key return", {4'h0, o_key_return_inputs}, {4'h0, i_p4_pin});
    // Serial, timer and interrupt pins through their alternate paths
    wr(16'hff02, 8'h07);
    i_serial_data_out = 1'b0;
    #1 chk("p2 out", {5'h00, o_p2_out}, 8'h05);
    chk("serial clock in", {7'h00, o_serial_clock_line}, 8'h01);
    chk("serial data in", {7'h00, o_serial_data_in}, 8'h01);
    i_serial_data_out = 1'b1;
    wr(16'hff26, 8'hfc);
    wr(16'hff06, 8'h00);
    i_timer_output_line = 1'b1;
    #1 chk("p6 out", {6'h00, o_p6_out}, 8'h01);
    chk("irq pin out", {7'h00, o_ext_irq_pin}, 8'h00);
    i_timer_output_line = 1'b0;
    wr(16'hff26, 8'hff);
    chk("irq pin in", {7'h00, o_ext_irq_pin}, {7'h00, ext[14]});
    $display("test alternate functions done");
    wr(16'hff10, 8'h55);
    rd(16'hff10, 8'hff, 8'h00);
    rd(16'hff20, 8'hff, 8'hfd);
    repeat (3) @(posedge i_mclk);
    $display("test segment and unmapped done");
    // Second reset in mid-run returns every pin to input
    @(posedge i_mclk);
    #1 i_arst_n = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1 i_arst_n = 1'b1;
    rd(16'hff20, 8'hff, 8'hff);
    rd(16'hff28, 8'hff, 8'h3f);
    rd(16'hfff7, 8'hff, 8'h00);
    rd(16'hff58, 8'hff, 8'h00);
    chk("seg enable", {2'b00, o_segment_enable}, 8'h00);
    chk("p0 pullup", {4'h0, o_p0_pullup}, 8'h00);
    $display("test second reset done");
    repeat (2) @(posedge i_mclk);
    chk("pending reads", 8'(q.size()), 8'h00);
    report_and_stop();
  end
endmodule // multi_port_io_direction_control_test
